// *** core/actuator_pkg.sv ***
package actuator_pkg;

	localparam logic [7:0] ID_SWITCH = 8'h64;
	localparam logic [7:0] ID_RUN = 8'h65;
	localparam logic [7:0] ID_TARGET = 8'h66;
	localparam logic [7:0] ID_POSITION = 8'h67;
	localparam logic [7:0] ID_REACHED = 8'h68;
	localparam logic [7:0] ID_BAND = 8'h69;
	localparam logic [7:0] ID_HOLD = 8'h6A;
	localparam logic [7:0] ID_FRC_RETR = 8'h6D;
	localparam logic [7:0] ID_FRC_EXTD = 8'h6E;
	localparam logic [7:0] ID_RETR_GOAL = 8'h6F;
	localparam logic [7:0] ID_EXTD_GOAL = 8'h70;
	localparam logic [7:0] ID_RETR_FLAG = 8'h71;
	localparam logic [7:0] ID_EXTD_FLAG = 8'h72;
	localparam logic [7:0] ID_RETR_THR = 8'h73;
	localparam logic [7:0] ID_EXTD_THR = 8'h74;
	localparam logic [7:0] ID_FAULT = 8'h75;

	localparam logic signed [15:0] POS_MIN = 16'shFFCE;
	localparam logic signed [15:0] POS_MAX = 16'sh2742;
	localparam logic signed [15:0] POS_FULL = 16'sh2710;
	localparam logic signed [15:0] POS_ZERO = 16'sh0000;
	localparam logic signed [15:0] QUANT_STEP = 16'sh000A;

	localparam logic [15:0] BAND_MIN = 16'h000A;
	localparam logic [15:0] BAND_MAX = 16'h03E8;
	localparam logic [15:0] BAND_RESET = 16'h0032;
	localparam logic [7:0] HOLD_RESET = 8'h00;
	localparam logic signed [15:0] RETR_GOAL_RESET = 16'sh2710;
	localparam logic signed [15:0] EXTD_GOAL_RESET = 16'sh0000;
	localparam logic signed [15:0] RETR_THR_RESET = 16'sh2648;
	localparam logic signed [15:0] EXTD_THR_RESET = 16'sh00C8;
	localparam logic signed [15:0] TARGET_RESET = 16'sh0000;

	localparam int CLK_HZ = 50000000;
	localparam int HOLD_STEP_MS = 100;
	localparam int HOLD_STEP_CYCLES = CLK_HZ / 1000 * HOLD_STEP_MS;
	localparam int HOLD_CNT_W = 31;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] id;
		logic [15:0] wdata;
	} attr_req_t;

	typedef struct packed {
		logic retract;
		logic extend;
	} motor_cmd_t;

	typedef enum logic [1:0] {
		SRC_STOP = 2'b00,
		SRC_TARGET = 2'b01,
		SRC_RETR = 2'b10,
		SRC_EXTD = 2'b11
	} src_t;

endpackage

// *** core/restart_hold.sv ***
`timescale 1ns/1ps
module restart_hold #(
	parameter int STEP_CYCLES = actuator_pkg::HOLD_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic stop_event,
	input wire logic [7:0] hold_time,
	output logic busy
);
	localparam int CW = actuator_pkg::HOLD_CNT_W;
	logic [CW-1:0] count_reg;

	// Load on the stop edge; a zero setting leaves the stem free at once
	always_ff @(posedge clk) begin
		if (reset) begin
			count_reg <= '0;
		end else if (stop_event) begin
			count_reg <= CW'(hold_time * STEP_CYCLES);
		end else if (count_reg != '0) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	assign busy = (count_reg != '0);

	a_hold_load: assert property (@(posedge clk) disable iff (reset)
		stop_event && hold_time != 8'h00 |=> busy)
		else $error("hold timer did not start after stop");
endmodule

// *** core/actuator_position_command_logic.sv ***
`timescale 1ns/1ps
module actuator_position_command_logic #(
	parameter int HOLD_STEP_CYCLES = actuator_pkg::HOLD_STEP_CYCLES
) (
	input wire logic MCLK,
	input wire logic RESET,
	input wire actuator_pkg::attr_req_t ATTR_REQ,
	input wire logic LOCAL_SW,
	input wire logic DIRECT_ACTION,
	input wire logic signed [15:0] STEM_POS,
	input wire logic MOTOR_DEADLOCK,
	input wire logic MEMORY_FAULT,
	output logic [15:0] ATTR_RDATA,
	output actuator_pkg::motor_cmd_t MOTOR_CMD,
	output logic ILLEGAL_INPUT
);
	logic run_reg;
	logic signed [15:0] target_reg;
	logic [15:0] band_reg;
	logic [7:0] hold_reg;
	logic frc_retr_reg;
	logic frc_extd_reg;
	logic signed [15:0] retr_goal_reg;
	logic signed [15:0] extd_goal_reg;
	logic signed [15:0] retr_thr_reg;
	logic signed [15:0] extd_thr_reg;
	logic illegal_reg;
	logic reached_reg;
	logic retr_flag_reg;
	logic extd_flag_reg;
	logic fault_reg;
	logic [15:0] rdata_reg;
	actuator_pkg::motor_cmd_t motor_reg;
	actuator_pkg::motor_cmd_t motor_next;
	actuator_pkg::src_t src;
	logic signed [15:0] setpoint;
	logic signed [16:0] err;
	logic [16:0] err_abs;
	logic in_band;
	logic wr_ok;
	logic stop_event;
	logic hold_busy;

	function automatic logic in_range(input logic signed [15:0] v,
		input logic signed [15:0] lo, input logic signed [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	function automatic logic wr_hit(input actuator_pkg::attr_req_t r, input logic [7:0] id);
		wr_hit = r.wr && (r.id == id);
	endfunction

	// Effective band width in 0.01%: odd tenths of a percent, 1..99 tenths
	function automatic logic [10:0] band_width(input logic [15:0] db);
		logic [15:0] tenths;
		tenths = db / 16'd10;
		if (tenths > 16'd99) begin
			tenths = 16'd99;
		end
		if (tenths[0] == 1'b0) begin
			tenths = (tenths == 16'd0) ? 16'd1 : tenths - 16'd1;
		end
		band_width = 11'(tenths * 16'd10);
	endfunction

	// Drop hundredths, truncating toward zero
	function automatic logic signed [15:0] quantize(input logic signed [15:0] v);
		quantize = v - (v % actuator_pkg::QUANT_STEP);
	endfunction

	assign wr_ok = ATTR_REQ.wr && !LOCAL_SW;

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			run_reg <= 1'b0;
			frc_retr_reg <= 1'b0;
			frc_extd_reg <= 1'b0;
		end else if (wr_ok) begin
			if (ATTR_REQ.id == actuator_pkg::ID_RUN) begin
				run_reg <= ATTR_REQ.wdata[0];
			end
			if (ATTR_REQ.id == actuator_pkg::ID_FRC_RETR) begin
				frc_retr_reg <= ATTR_REQ.wdata[0];
			end
			if (ATTR_REQ.id == actuator_pkg::ID_FRC_EXTD) begin
				frc_extd_reg <= ATTR_REQ.wdata[0];
			end
		end
	end

	// Out-of-range target keeps the previous one but raises the illegal flag
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			target_reg <= actuator_pkg::TARGET_RESET;
			illegal_reg <= 1'b0;
		end else if (wr_ok && wr_hit(ATTR_REQ, actuator_pkg::ID_TARGET)) begin
			if (in_range(ATTR_REQ.wdata, actuator_pkg::POS_MIN, actuator_pkg::POS_MAX)) begin
				target_reg <= quantize(ATTR_REQ.wdata);
				illegal_reg <= 1'b0;
			end else begin
				illegal_reg <= 1'b1;
			end
		end
	end

	// Band, goal and threshold settings outside their range are refused and the old value kept; hold takes the low byte of any write
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			band_reg <= actuator_pkg::BAND_RESET;
			hold_reg <= actuator_pkg::HOLD_RESET;
			retr_goal_reg <= actuator_pkg::RETR_GOAL_RESET;
			extd_goal_reg <= actuator_pkg::EXTD_GOAL_RESET;
			retr_thr_reg <= actuator_pkg::RETR_THR_RESET;
			extd_thr_reg <= actuator_pkg::EXTD_THR_RESET;
		end else if (wr_ok) begin
			case (ATTR_REQ.id)
				actuator_pkg::ID_BAND: begin
					if (ATTR_REQ.wdata >= actuator_pkg::BAND_MIN &&
						ATTR_REQ.wdata <= actuator_pkg::BAND_MAX) begin
						band_reg <= ATTR_REQ.wdata;
					end
				end
				actuator_pkg::ID_HOLD: begin
					hold_reg <= ATTR_REQ.wdata[7:0];
				end
				actuator_pkg::ID_RETR_GOAL: begin
					if (in_range(ATTR_REQ.wdata, actuator_pkg::POS_ZERO, actuator_pkg::POS_MAX)) begin
						retr_goal_reg <= ATTR_REQ.wdata;
					end
				end
				actuator_pkg::ID_EXTD_GOAL: begin
					if (in_range(ATTR_REQ.wdata, actuator_pkg::POS_MIN, actuator_pkg::POS_FULL)) begin
						extd_goal_reg <= ATTR_REQ.wdata;
					end
				end
				actuator_pkg::ID_RETR_THR: begin
					if (in_range(ATTR_REQ.wdata, actuator_pkg::POS_ZERO, actuator_pkg::POS_MAX)) begin
						retr_thr_reg <= ATTR_REQ.wdata;
					end
				end
				actuator_pkg::ID_EXTD_THR: begin
					if (in_range(ATTR_REQ.wdata, actuator_pkg::POS_MIN, actuator_pkg::POS_FULL)) begin
						extd_thr_reg <= ATTR_REQ.wdata;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Local switch hands the stem to manual control, so the motor stays idle here
	always_comb begin
		if (LOCAL_SW || !run_reg) begin
			src = actuator_pkg::SRC_STOP;
		end else if (frc_retr_reg) begin
			src = actuator_pkg::SRC_RETR;
		end else if (frc_extd_reg) begin
			src = actuator_pkg::SRC_EXTD;
		end else begin
			src = actuator_pkg::SRC_TARGET;
		end
	end

	always_comb begin
		case (src)
			actuator_pkg::SRC_RETR: setpoint = retr_goal_reg;
			actuator_pkg::SRC_EXTD: setpoint = extd_goal_reg;
			actuator_pkg::SRC_TARGET: setpoint = DIRECT_ACTION ?
				16'(actuator_pkg::POS_FULL - target_reg) : target_reg;
			default: setpoint = STEM_POS;
		endcase
	end

	assign err = 17'(setpoint) - 17'(STEM_POS);
	assign err_abs = err[16] ? 17'(-err) : err;
	assign in_band = ({err_abs, 1'b0} <= 18'(band_width(band_reg)));

	always_comb begin
		motor_next = '0;
		if (src != actuator_pkg::SRC_STOP && !in_band && !hold_busy) begin
			motor_next.retract = err[16] ? 1'b0 : 1'b1;
			motor_next.extend = err[16];
		end
	end

	assign stop_event = (motor_reg != '0) && (motor_next == '0);

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			motor_reg <= '0;
		end else begin
			motor_reg <= motor_next;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			reached_reg <= 1'b0;
			retr_flag_reg <= 1'b0;
			extd_flag_reg <= 1'b0;
			fault_reg <= 1'b0;
		end else begin
			reached_reg <= in_band;
			retr_flag_reg <= (STEM_POS > retr_thr_reg);
			extd_flag_reg <= (STEM_POS < extd_thr_reg);
			fault_reg <= MOTOR_DEADLOCK || illegal_reg || MEMORY_FAULT;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			rdata_reg <= 16'h0000;
		end else if (ATTR_REQ.rd) begin
			case (ATTR_REQ.id)
				actuator_pkg::ID_SWITCH: rdata_reg <= {15'h0000, LOCAL_SW};
				actuator_pkg::ID_RUN: rdata_reg <= {15'h0000, run_reg};
				actuator_pkg::ID_TARGET: rdata_reg <= target_reg;
				actuator_pkg::ID_POSITION: rdata_reg <= STEM_POS;
				actuator_pkg::ID_REACHED: rdata_reg <= {15'h0000, reached_reg};
				actuator_pkg::ID_BAND: rdata_reg <= band_reg;
				actuator_pkg::ID_HOLD: rdata_reg <= {8'h00, hold_reg};
				actuator_pkg::ID_RETR_GOAL: rdata_reg <= retr_goal_reg;
				actuator_pkg::ID_EXTD_GOAL: rdata_reg <= extd_goal_reg;
				actuator_pkg::ID_RETR_FLAG: rdata_reg <= {15'h0000, retr_flag_reg};
				actuator_pkg::ID_EXTD_FLAG: rdata_reg <= {15'h0000, extd_flag_reg};
				actuator_pkg::ID_RETR_THR: rdata_reg <= retr_thr_reg;
				actuator_pkg::ID_EXTD_THR: rdata_reg <= extd_thr_reg;
				actuator_pkg::ID_FAULT: rdata_reg <= {15'h0000, fault_reg};
				default: rdata_reg <= 16'h0000;
			endcase
		end
	end

	restart_hold #(
		.STEP_CYCLES(HOLD_STEP_CYCLES)
	) u_hold (
		.clk(MCLK),
		.reset(RESET),
		.stop_event(stop_event),
		.hold_time(hold_reg),
		.busy(hold_busy)
	);

	assign ATTR_RDATA = rdata_reg;
	assign MOTOR_CMD = motor_reg;
	assign ILLEGAL_INPUT = illegal_reg;

	sequence s_bad_target;
		ATTR_REQ.wr && !LOCAL_SW && ATTR_REQ.id == actuator_pkg::ID_TARGET &&
			!in_range(ATTR_REQ.wdata, actuator_pkg::POS_MIN, actuator_pkg::POS_MAX);
	endsequence

	a_local_run_hold: assert property (@(posedge MCLK) disable iff (RESET)
		LOCAL_SW && wr_hit(ATTR_REQ, actuator_pkg::ID_RUN) |=> $stable(run_reg))
		else $error("run command changed while local");
	a_stop_no_run: assert property (@(posedge MCLK) disable iff (RESET)
		!run_reg |=> MOTOR_CMD == '0)
		else $error("motor moving without run command");
	a_target_quant: assert property (@(posedge MCLK) disable iff (RESET)
		target_reg % actuator_pkg::QUANT_STEP == 0)
		else $error("target keeps hundredths");
	a_retr_wins: assert property (@(posedge MCLK) disable iff (RESET)
		run_reg && !LOCAL_SW && frc_retr_reg |-> setpoint == retr_goal_reg)
		else $error("forced retract not followed");
	a_goal_range: assert property (@(posedge MCLK) disable iff (RESET)
		retr_goal_reg >= actuator_pkg::POS_ZERO && extd_goal_reg <= actuator_pkg::POS_FULL)
		else $error("forced goal out of range");
	a_reached_flag: assert property (@(posedge MCLK) disable iff (RESET)
		in_band |=> reached_reg)
		else $error("reached flag not set in band");
	a_retr_flag: assert property (@(posedge MCLK) disable iff (RESET)
		STEM_POS > retr_thr_reg ##1 $stable(retr_thr_reg) |-> retr_flag_reg)
		else $error("retract end flag missing");
	a_extd_flag: assert property (@(posedge MCLK) disable iff (RESET)
		STEM_POS >= extd_thr_reg ##1 $stable(extd_thr_reg) |-> !extd_flag_reg)
		else $error("extend end flag false");
	a_fault_sum: assert property (@(posedge MCLK) disable iff (RESET)
		(MOTOR_DEADLOCK || MEMORY_FAULT || illegal_reg) |=> fault_reg)
		else $error("summary fault not raised");
	a_illegal_set: assert property (@(posedge MCLK) disable iff (RESET)
		s_bad_target |=> ILLEGAL_INPUT && $stable(target_reg))
		else $error("illegal target accepted");
	a_band_stop: assert property (@(posedge MCLK) disable iff (RESET)
		in_band || hold_busy |=> MOTOR_CMD == '0)
		else $error("motor running inside band or hold");
endmodule

// *** dv/stem_plant.sv ***
`timescale 1ns/1ps
module stem_plant (
	input wire logic clk,
	input wire logic reset,
	input wire actuator_pkg::motor_cmd_t cmd,
	output logic signed [15:0] pos
);
	// A tenth of a percent a cycle keeps a full stroke short in simulation
	always_ff @(posedge clk) begin
		if (reset) begin
			pos <= 16'sh0000;
		end else if (cmd.retract && pos < 16'sh2742) begin
			pos <= pos + 16'sh000A;
		end else if (cmd.extend && pos > -16'sh0032) begin
			pos <= pos - 16'sh000A;
		end
	end
endmodule

// *** dv/actuator_position_command_logic_tb_top.sv ***
`timescale 1ns/1ps
module actuator_position_command_logic_tb_top;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	actuator_pkg::attr_req_t req = '0;
	logic local_sw = 1'b0;
	logic direct_action = 1'b0;
	logic motor_deadlock = 1'b0;
	logic memory_fault = 1'b0;
	logic signed [15:0] stem_pos;
	logic [15:0] rdata;
	actuator_pkg::motor_cmd_t motor_cmd;
	logic illegal_input;
	int n_errors = 0;
	int checks = 0;

	always #10 mclk = ~mclk;

	actuator_position_command_logic #(.HOLD_STEP_CYCLES(4)) actuator_position_command_logic_i (
		.MCLK(mclk), .RESET(reset), .ATTR_REQ(req), .LOCAL_SW(local_sw),
		.DIRECT_ACTION(direct_action), .STEM_POS(stem_pos), .MOTOR_DEADLOCK(motor_deadlock),
		.MEMORY_FAULT(memory_fault), .ATTR_RDATA(rdata), .MOTOR_CMD(motor_cmd),
		.ILLEGAL_INPUT(illegal_input)
	);
	stem_plant stem_plant_i (.clk(mclk), .reset(reset), .cmd(motor_cmd), .pos(stem_pos));

	task automatic summarize;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] id, input logic [15:0] d);
		@(negedge mclk);
		req = '{wr: 1'b1, rd: 1'b0, id: id, wdata: d};
		@(negedge mclk);
		req = '0;
	endtask

	// Read data stands until the next read, so one spare cycle costs nothing
	task automatic rchk(input string name, input logic [7:0] id, input logic [15:0] exp);
		@(negedge mclk);
		req = '{wr: 1'b0, rd: 1'b1, id: id, wdata: 16'h0000};
		@(negedge mclk);
		req = '0;
		@(negedge mclk);
		chk(name, exp, rdata);
	endtask

	task automatic settle(input logic signed [15:0] sp, input int tol);
		int quiet;
		quiet = 0;
		for (int i = 0; i < 2500 && quiet < 6; i++) begin
			@(negedge mclk);
			quiet = (motor_cmd === 2'b00) ? quiet + 1 : 0;
		end
		chk("stopped", 16'h0006, 16'(quiet));
		if (quiet < 6) summarize();
		rchk("position_reached_flag", 8'h68, 16'h0001);
		chk("near setpoint", 16'h0001, 16'(stem_pos <= sp + tol && stem_pos >= sp - tol));
		rchk("stem_position_readback", 8'h67, stem_pos);
	endtask

	task automatic wait_move(input int n);
		for (int i = 0; i < n && motor_cmd === 2'b00; i++) @(negedge mclk);
		chk("moving", 16'h0001, 16'(motor_cmd !== 2'b00));
		if (motor_cmd === 2'b00) summarize();
	endtask

	initial begin
		repeat (16) @(negedge mclk);
		reset = 1'b0;
		rchk("tolerance_band_setting", 8'h69, 16'h0032);
		rchk("restart_hold_time", 8'h6A, 16'h0000);
		rchk("force_retract_goal", 8'h6F, 16'h2710);
		rchk("force_extend_goal", 8'h70, 16'h0000);
		wr(8'h6F, 16'hFFCE);
		rchk("force_retract_goal", 8'h6F, 16'h2710);
		rchk("retract_end_threshold", 8'h73, 16'h2648);
		rchk("extend_end_threshold", 8'h74, 16'h00C8);
		rchk("force_retract_cmd", 8'h6D, 16'h0000);
		rchk("unmapped", 8'h80, 16'h0000);
		local_sw = 1'b1;
		rchk("manual_switch_state", 8'h64, 16'h0001);
		wr(8'h65, 16'h0001);
		rchk("run_command", 8'h65, 16'h0000);
		local_sw = 1'b0;
		rchk("manual_switch_state", 8'h64, 16'h0000);
		wr(8'h69, 16'h0009);
		rchk("tolerance_band_setting", 8'h69, 16'h0032);
		wr(8'h65, 16'h0001);
		rchk("run_command", 8'h65, 16'h0001);
		wr(8'h66, 16'd1239);
		rchk("target_setpoint", 8'h66, 16'd1230);
		settle(16'sd1230, 35);
		wr(8'h66, 16'h2743);
		rchk("target_setpoint", 8'h66, 16'd1230);
		@(negedge mclk);
		chk("illegal", 16'h0001, 16'(illegal_input));
		rchk("summary_fault_flag", 8'h75, 16'h0001);
		chk("motor idle", 16'h0000, 16'(motor_cmd));
		wr(8'h66, 16'hFFCE);
		@(negedge mclk);
		chk("illegal", 16'h0000, 16'(illegal_input));
		settle(-16'sd50, 35);
		rchk("extend_end_flag", 8'h72, 16'h0001);
		rchk("retract_end_flag", 8'h71, 16'h0000);
		for (int k = 0; k < 2; k++) begin
			{motor_deadlock, memory_fault} = k ? 2'b01 : 2'b10;
			rchk("summary_fault_flag", 8'h75, 16'h0001);
		end
		{motor_deadlock, memory_fault} = 2'b00;
		rchk("summary_fault_flag", 8'h75, 16'h0000);
		wr(8'h6D, 16'h0001);
		wr(8'h6E, 16'h0001);
		settle(16'sd10000, 35);
		rchk("retract_end_flag", 8'h71, 16'h0001);
		rchk("extend_end_flag", 8'h72, 16'h0000);
		wr(8'h70, 16'd400);
		wr(8'h6D, 16'h0000);
		settle(16'sd400, 35);
		wr(8'h6E, 16'h0000);
		direct_action = 1'b1;
		wr(8'h66, 16'd2000);
		settle(16'sd8000, 35);
		direct_action = 1'b0;
		wr(8'h69, 16'd1000);
		wr(8'h66, 16'd5000);
		settle(16'sd5490, 45);
		wr(8'h69, 16'h0032);
		wr(8'h6A, 16'h000A);
		rchk("restart_hold_time", 8'h6A, 16'h000A);
		wr(8'h66, 16'h0000);
		wait_move(60);
		rchk("position_reached_flag", 8'h68, 16'h0000);
		wr(8'h65, 16'h0000);
		repeat (3) @(negedge mclk);
		chk("stopped by run", 16'h0000, 16'(motor_cmd));
		wr(8'h65, 16'h0001);
		for (int i = 0; i < 20; i++) begin
			@(negedge mclk);
			chk("restart held", 16'h0000, 16'(motor_cmd));
		end
		wait_move(60);
		settle(16'sd0, 35);
		summarize();
	end
endmodule
